// >>> core/flash_dma_engine.sv
// command-buffer spi flash transfer engine with byte dma master
`timescale 1ns/1ps
`default_nettype none

module flash_dma_engine (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              ce,
	input  wire logic              link_clk,
	input  wire logic              link_resetn,
	input  wire flash_pkg::cfg_t   cfg,
	input  wire logic              transaction_go_set,
	input  wire logic              complete_clear,
	input  wire logic              ulp_enter,
	input  wire logic              flash_supply_control,
	output logic                   transaction_go,
	output logic                   transaction_complete,
	output logic                   busy,
	output logic [31:0]            command_bytes_low,
	output logic [31:0]            command_bytes_high,
	output logic                   flash_supply_en,
	output flash_pkg::mem_req_t    mem_req,
	input  wire logic              mem_ack,
	input  wire logic [31:0]       mem_rdata,
	output logic                   ssn_n,
	output logic                   sck,
	output logic                   mosi,
	input  wire logic              miso
);

	flash_pkg::engine_reg_t r_reg;
	flash_pkg::engine_reg_t r_next;
	logic                   ack_tog;
	logic [7:0]             rx_byte;
	logic                   ack_edge;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [1:0] lane_of(input logic [1:0] off,
		input logic little);
		lane_of = little ? off : 2'h3 - off;
	endfunction

	function automatic logic [7:0] fill_byte(input flash_pkg::cfg_t c);
		if (c.fill_pattern)
			fill_byte = c.pattern_byte;
		else if (c.fill_toggle)
			fill_byte = flash_pkg::FILL_TOGGLE;
		else if (c.fill_one)
			fill_byte = flash_pkg::FILL_ONES;
		else
			fill_byte = flash_pkg::FILL_ZEROS;
	endfunction

	// ----------------------------------------------------------------
	// link side
	// ----------------------------------------------------------------
	spi_byte_shifter u_shift (
		.link_clk    (link_clk),
		.link_resetn (link_resetn),
		.req_tog     (r_reg.req),
		.tx_byte     (r_reg.tx),
		.ack_tog     (ack_tog),
		.rx_byte     (rx_byte),
		.sck         (sck),
		.mosi        (mosi),
		.miso        (miso)
	);

	// rx_byte is steady once the ack toggle has crossed
	assign ack_edge = r_reg.s2 ^ r_reg.s3;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		r_next        = r_reg;
		r_next.s1     = ack_tog;
		r_next.s2     = r_reg.s1;
		r_next.s3     = r_reg.s2;
		r_next.supply = flash_supply_control;
		if (complete_clear)
			r_next.done = 1'b0;
		if (transaction_go_set)
			r_next.go = 1'b1;
		case (r_reg.st)
			flash_pkg::ST_IDLE:
			begin
				if (r_reg.go)
				begin
					r_next.go   = 1'b0;
					r_next.cbuf = {cfg.command_bytes_high,
						cfg.command_bytes_low};
					r_next.idx  = 3'h0;
					r_next.left = (cfg.command_count == 3'h0) ?
						flash_pkg::CMD_BYTES_MAX :
						{1'b0, cfg.command_count};
					r_next.addr = cfg.dma_start_address;
					r_next.wcnt = cfg.write_count;
					r_next.rcnt = cfg.read_count;
					r_next.cs   = 1'b1;
					r_next.st   = flash_pkg::ST_NEXT;
				end
			end
			flash_pkg::ST_NEXT:
			begin
				if (r_reg.left != 4'h0)
				begin
					r_next.tx  = cfg.direction[r_reg.idx] ?
						r_reg.cbuf[8 * r_reg.idx +: 8] : fill_byte(cfg);
					r_next.req = ~r_reg.req;
					r_next.st  = flash_pkg::ST_XFER_CMD;
				end
				else if (r_reg.wcnt != 24'h0)
				begin
					r_next.mem.valid = 1'b1;
					r_next.mem.write = 1'b0;
					r_next.mem.addr  = r_reg.addr;
					r_next.mem.be    = flash_pkg::LANE_BE_BYTE <<
						lane_of(r_reg.addr[1:0], cfg.endian_little);
					r_next.st        = flash_pkg::ST_FETCH;
				end
				else if (r_reg.rcnt != 24'h0)
				begin
					r_next.tx  = fill_byte(cfg);
					r_next.req = ~r_reg.req;
					r_next.st  = flash_pkg::ST_XFER_RD;
				end
				else
				begin
					r_next.cs   = 1'b0;
					r_next.done = 1'b1;
					r_next.st   = flash_pkg::ST_IDLE;
				end
			end
			flash_pkg::ST_XFER_CMD:
			begin
				if (ack_edge)
				begin
					if (!cfg.direction[r_reg.idx])
						r_next.cbuf[8 * r_reg.idx +: 8] = rx_byte;
					r_next.idx  = r_reg.idx + 3'h1;
					r_next.left = r_reg.left - 4'h1;
					r_next.st   = flash_pkg::ST_NEXT;
				end
			end
			flash_pkg::ST_FETCH:
			begin
				if (mem_ack)
				begin
					r_next.tx = mem_rdata[8 * lane_of(r_reg.addr[1:0],
						cfg.endian_little) +: 8];
					r_next.mem.valid = 1'b0;
					r_next.req  = ~r_reg.req;
					r_next.addr = r_reg.addr + 32'h0000_0001;
					r_next.wcnt = r_reg.wcnt - 24'h00_0001;
					r_next.st   = flash_pkg::ST_XFER_WR;
				end
			end
			flash_pkg::ST_XFER_WR:
			begin
				// write bytes stream behind the commands
				if (ack_edge)
					r_next.st = flash_pkg::ST_NEXT;
			end
			flash_pkg::ST_XFER_RD:
			begin
				if (ack_edge)
				begin
					r_next.mem.valid = 1'b1;
					r_next.mem.write = 1'b1;
					r_next.mem.addr  = r_reg.addr;
					r_next.mem.wdata = {24'h00_0000, rx_byte} <<
						(8 * lane_of(r_reg.addr[1:0], cfg.endian_little));
					r_next.mem.be    = flash_pkg::LANE_BE_BYTE <<
						lane_of(r_reg.addr[1:0], cfg.endian_little);
					r_next.st        = flash_pkg::ST_STORE;
				end
			end
			flash_pkg::ST_STORE:
			begin
				if (mem_ack)
				begin
					r_next.mem.valid = 1'b0;
					r_next.addr = r_reg.addr + 32'h0000_0001;
					r_next.rcnt = r_reg.rcnt - 24'h00_0001;
					r_next.st   = flash_pkg::ST_NEXT;
				end
			end
			default:
				r_next.st = flash_pkg::ST_IDLE;
		endcase
		if (ulp_enter)
		begin
			r_next     = '0;
			// the link side keeps its toggles, so ours stay in step
			// with them or a phantom byte would follow the wake
			r_next.req = r_reg.req;
			r_next.s1  = ack_tog;
			r_next.s2  = r_reg.s1;
			r_next.s3  = r_reg.s2;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			r_reg <= '0;
		else if (ce)
			r_reg <= r_next;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign transaction_go       = r_reg.go;
	assign transaction_complete = r_reg.done;
	assign busy                 = r_reg.cs;
	assign command_bytes_low    = r_reg.cbuf[31:0];
	assign command_bytes_high   = r_reg.cbuf[63:32];
	assign flash_supply_en      = r_reg.supply;
	assign mem_req              = r_reg.mem;
	assign ssn_n                = ~r_reg.cs;

endmodule // flash_dma_engine

`default_nettype wire

// >>> inc/flash_pkg.sv
// shared types and constants of the flash transfer engine
package flash_pkg;

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam logic [3:0] CMD_BYTES_MAX   = 4'h8;
	localparam logic [5:0] BYTE_END_COUNT  = 6'h20;
	localparam logic [7:0] FILL_ZEROS      = 8'h00;
	localparam logic [7:0] FILL_ONES       = 8'hff;
	localparam logic [7:0] FILL_TOGGLE     = 8'haa;
	localparam logic [3:0] LANE_BE_BYTE    = 4'h1;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] command_bytes_low;
		logic [31:0] command_bytes_high;
		logic [7:0]  direction;
		logic [2:0]  command_count;
		logic [23:0] write_count;
		logic [23:0] read_count;
		logic [31:0] dma_start_address;
		logic        endian_little;
		logic        fill_zero;
		logic        fill_one;
		logic        fill_toggle;
		logic        fill_pattern;
		logic [7:0]  pattern_byte;
	} cfg_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be;
	} mem_req_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_NEXT,
		ST_XFER_CMD,
		ST_FETCH,
		ST_XFER_WR,
		ST_XFER_RD,
		ST_STORE
	} engine_state_t;

	typedef struct packed {
		engine_state_t st;
		logic [63:0]   cbuf;
		logic [2:0]    idx;
		logic [3:0]    left;
		logic [23:0]   wcnt;
		logic [23:0]   rcnt;
		logic [31:0]   addr;
		logic [7:0]    tx;
		logic          req;
		logic          s1;
		logic          s2;
		logic          s3;
		logic          go;
		logic          done;
		logic          cs;
		logic          supply;
		mem_req_t      mem;
	} engine_reg_t;

	typedef struct packed {
		logic       q1;
		logic       q2;
		logic       q3;
		logic       m1;
		logic       m2;
		logic       busy;
		logic [5:0] cnt;
		logic [7:0] sh;
		logic [7:0] rx;
		logic       ack;
	} shift_reg_t;

endpackage

// >>> core/spi_byte_shifter.sv
// link-clock byte shifter: one spi byte per request toggle
`timescale 1ns/1ps
`default_nettype none

module spi_byte_shifter (
	input  wire logic       link_clk,
	input  wire logic       link_resetn,
	input  wire logic       req_tog,
	input  wire logic [7:0] tx_byte,
	output logic            ack_tog,
	output logic [7:0]      rx_byte,
	output logic            sck,
	output logic            mosi,
	input  wire logic       miso
);

	flash_pkg::shift_reg_t r_reg;
	flash_pkg::shift_reg_t r_next;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		r_next    = r_reg;
		r_next.q1 = req_tog;
		r_next.q2 = r_reg.q1;
		r_next.q3 = r_reg.q2;
		r_next.m1 = miso;
		r_next.m2 = r_reg.m1;
		if (!r_reg.busy)
		begin
			// tx_byte is held steady by the sender until our ack
			if (r_reg.q2 ^ r_reg.q3)
			begin
				r_next.busy = 1'b1;
				r_next.cnt  = 6'h0;
				r_next.sh   = tx_byte;
			end
		end
		else
		begin
			r_next.cnt = r_reg.cnt + 6'h1;
			if (r_reg.cnt[1:0] == 2'h3)
				r_next.sh = {r_reg.sh[6:0], 1'b0};
			// sample half a bit late to absorb the two miso sync stages
			if (r_reg.cnt[1:0] == 2'h0 && r_reg.cnt != 6'h0)
				r_next.rx = {r_reg.rx[6:0], r_reg.m2};
			if (r_reg.cnt == flash_pkg::BYTE_END_COUNT)
			begin
				r_next.busy = 1'b0;
				r_next.ack  = ~r_reg.ack;
			end
		end
	end

	always_ff @(posedge link_clk)
	begin
		if (!link_resetn)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign ack_tog = r_reg.ack;
	assign rx_byte = r_reg.rx;
	assign mosi    = r_reg.sh[7];
	assign sck     = r_reg.busy & r_reg.cnt[1] & ~r_reg.cnt[5];

endmodule // spi_byte_shifter

`default_nettype wire

// >>> sim/flash_dma_engine_props.sv
// port checks of the flash transfer engine
`timescale 1ns/1ps
`default_nettype none

module flash_dma_engine_props (
	input wire logic                clk,
	input wire logic                resetn,
	input wire logic                ulp_enter,
	input wire logic                complete_clear,
	input wire flash_pkg::cfg_t     cfg,
	input wire logic                transaction_go,
	input wire logic                transaction_complete,
	input wire logic                busy,
	input wire logic                ssn_n,
	input wire logic                sck,
	input wire flash_pkg::mem_req_t mem_req,
	input wire logic                mem_ack
);
	default clocking @(posedge clk); endclocking
	// ulp wipes state at once, so ordinary relations pause around it
	default disable iff (!resetn || ulp_enter);

	a_launch_cause: assert property (
		$rose(busy) |-> $past(transaction_go)) else $error("busy without start");
	a_go_clears: assert property (
		$rose(busy) |-> !transaction_go) else $error("start bit kept");
	a_done_sticky: assert property (
		transaction_complete && !complete_clear |=> transaction_complete)
		else $error("done flag dropped");
	a_done_end: assert property (
		$fell(busy) |-> ##[0:3] transaction_complete) else $error("no done");
	a_select_busy: assert property (
		busy != ssn_n) else $error("select differs from busy");
	a_req_hold: assert property (
		mem_req.valid && !mem_ack |=> mem_req.valid && $stable(mem_req))
		else $error("request moved before ack");
	a_req_drop: assert property (
		mem_req.valid && mem_ack |=> !mem_req.valid) else $error("valid kept");
	a_mem_busy: assert property (
		mem_req.valid |-> busy) else $error("memory request while idle");
	a_lane_little: assert property (
		mem_req.valid && cfg.endian_little
		|-> mem_req.be == 4'h1 << mem_req.addr[1:0]) else $error("lane little");
	a_lane_big: assert property (
		mem_req.valid && !cfg.endian_little
		|-> mem_req.be == 4'h8 >> mem_req.addr[1:0]) else $error("lane big");
	a_ulp_wipe: assert property (disable iff (!resetn)
		ulp_enter |=> !transaction_complete && !transaction_go && !busy)
		else $error("state survived ulp");
	a_sck_framed: assert property (
		ssn_n |-> !sck) else $error("serial clock outside frame");
endmodule // flash_dma_engine_props

bind flash_dma_engine flash_dma_engine_props u_flash_dma_engine_props (
	.clk(clk), .resetn(resetn), .ulp_enter(ulp_enter),
	.complete_clear(complete_clear), .cfg(cfg),
	.transaction_go(transaction_go),
	.transaction_complete(transaction_complete), .busy(busy),
	.ssn_n(ssn_n), .sck(sck), .mem_req(mem_req), .mem_ack(mem_ack));

`default_nettype wire

// >>> sim/flash_memory_model.sv
// serial flash stand-in: logs mosi bytes, sends 0x30 + byte index
`timescale 1ns/1ps
`default_nettype none

module flash_memory_model (
	input wire logic ssn_n,
	input wire logic sck,
	input wire logic mosi,
	output logic     miso
);
	logic [7:0] got [0:15];
	logic [7:0] rx;
	logic [7:0] tx;
	int         nbit = 0;

	initial miso = 1'b0;
	always @(negedge ssn_n)
	begin
		nbit = 0;
		tx = 8'h30;
		miso = tx[7];
	end
	always @(posedge sck)
	if (!ssn_n)
	begin
		rx = {rx[6:0], mosi};
		nbit++;
		if (nbit % 8 == 0)
			got[(nbit / 8 - 1) % 16] = rx;
	end
	always @(negedge sck)
	if (!ssn_n)
	begin
		if (nbit % 8 == 0)
			tx = 8'(8'h30 + nbit / 8);
		miso = tx[7 - nbit % 8];
	end
	// released line must not keep its last bit
	always @(posedge ssn_n) miso = ~miso;
endmodule // flash_memory_model

`default_nettype wire

// >>> sim/spi_flash_dma_transfer_engine_test.sv
// self-checking bench of the flash transfer engine
`timescale 1ns/1ps
`default_nettype none

module spi_flash_dma_transfer_engine_test;
	logic                clk = 1'b0;
	logic                link_clk = 1'b0;
	logic                resetn = 1'b0;
	logic                go_set = 1'b0;
	logic                clr = 1'b0;
	logic                ulp = 1'b0;
	logic                supply = 1'b0;
	logic                mem_ack = 1'b0;
	logic [31:0]         mem_rdata = 32'h0000_0000;
	flash_pkg::cfg_t     cfg = '0;
	flash_pkg::mem_req_t mem_req;
	logic                go, done, busy, sup_en, ssn_n, sck, mosi, miso;
	logic [31:0]         cb_lo, cb_hi;
	logic [7:0]          mem [0:63];
	logic [1:0]          lane;
	logic [7:0]          fill_exp [0:3] = '{8'h00, 8'hff, 8'haa, 8'h5c};
	int                  error_cnt = 0;
	int                  n_tests = 0;

	always #2 clk = ~clk;
	initial
	begin
		#1.3;
		forever #3 link_clk = ~link_clk;
	end

	flash_dma_engine u_flash_dma_engine (.clk(clk), .resetn(resetn),
		.ce(1'b1), .link_clk(link_clk), .link_resetn(resetn), .cfg(cfg),
		.transaction_go_set(go_set), .complete_clear(clr), .ulp_enter(ulp),
		.flash_supply_control(supply), .transaction_go(go),
		.transaction_complete(done), .busy(busy), .command_bytes_low(cb_lo),
		.command_bytes_high(cb_hi), .flash_supply_en(sup_en),
		.mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.ssn_n(ssn_n), .sck(sck), .mosi(mosi), .miso(miso));
	flash_memory_model u_flash_memory_model (.ssn_n(ssn_n), .sck(sck),
		.mosi(mosi), .miso(miso));

	// --------
	// memory slave, one byte in its endian lane
	// --------
	assign lane = cfg.endian_little ? mem_req.addr[1:0]
		: 2'h3 - mem_req.addr[1:0];
	always @(posedge clk)
	begin
		mem_ack <= mem_req.valid && !mem_ack;
		mem_rdata <= {24'h00_0000, mem[mem_req.addr[5:0]]} << (8 * lane);
		if (mem_req.valid && mem_ack && mem_req.write)
			mem[mem_req.addr[5:0]] <= 8'(mem_req.wdata >> (8 * lane));
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
	begin
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	end
	endtask

	task automatic run(input logic [2:0] n, input logic [31:0] lo, hi,
		input logic [7:0] dir, input logic [23:0] wc, rc,
		input logic [31:0] adr, input logic little);
	begin
		@(posedge clk);
		cfg.command_count <= n;
		cfg.command_bytes_low <= lo;
		cfg.command_bytes_high <= hi;
		cfg.direction <= dir;
		cfg.write_count <= wc;
		cfg.read_count <= rc;
		cfg.dma_start_address <= adr;
		cfg.endian_little <= little;
		go_set <= 1'b1;
		@(posedge clk) go_set <= 1'b0;
		for (int t = 0; t < 3000 && done !== 1'b1; t++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		chk(8'(done), 8'h01);
		clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		@(posedge clk) chk(8'(done), 8'h00);
	end
	endtask

	task automatic give_verdict;
	begin
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask

	initial
	begin
		#60000;
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		for (int i = 0; i < 64; i++)
			mem[i] = 8'(i);
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		supply <= 1'b1;
		cfg.pattern_byte <= 8'h5c;
		// every fill mode on a received command byte
		for (int m = 0; m < 4; m++)
		begin
			{cfg.fill_pattern, cfg.fill_toggle, cfg.fill_one,
				cfg.fill_zero} <= 4'h1 << m;
			run(3'h2, 32'h0000_0003, 32'h0, 8'h01, 24'h0, 24'h0,
				32'h0, 1'b1);
			chk(u_flash_memory_model.got[1], fill_exp[m]);
			chk(cb_lo[15:8], 8'h31);
			chk(cb_lo[7:0], 8'h03);
		end
		// read with dummy byte, big endian stores
		run(3'h5, 32'h3322_1103, 32'h0000_00d5, 8'h1f, 24'h0, 24'h6,
			32'h0000_0011, 1'b0);
		chk(u_flash_memory_model.got[1], 8'h11);
		chk(u_flash_memory_model.got[4], 8'hd5);
		chk(cb_hi[7:0], 8'hd5);
		chk(8'(u_flash_memory_model.nbit / 8), 8'h0b);
		for (int i = 0; i < 6; i++)
			chk(mem[8'h11 + i], 8'(8'h35 + i));
		chk(mem[8'h17], 8'h17);
		// write data fetched little endian
		run(3'h4, 32'h2211_0002, 32'h0, 8'h0f, 24'h3, 24'h0,
			32'h0000_0021, 1'b1);
		for (int i = 0; i < 3; i++)
			chk(u_flash_memory_model.got[4 + i], 8'(8'h21 + i));
		chk(8'(u_flash_memory_model.nbit / 8), 8'h07);
		chk(8'(sup_en), 8'h01);
		// low-power command goes out before the supply is dropped
		run(3'h1, 32'h0000_00a5, 32'h0, 8'h01, 24'h0, 24'h0,
			32'h0, 1'b1);
		chk(u_flash_memory_model.got[0], 8'ha5);
		supply <= 1'b0;
		repeat (2) @(posedge clk);
		chk(8'(sup_en), 8'h00);
		// ulp right as a start is pending
		@(posedge clk) go_set <= 1'b1;
		@(posedge clk)
		begin
			go_set <= 1'b0;
			ulp <= 1'b1;
		end
		@(posedge clk) ulp <= 1'b0;
		repeat (2) @(posedge clk);
		chk({6'h00, go, busy}, 8'h00);
		chk(cb_lo[7:0], 8'h00);
		// full reprogram after wake; count zero means eight bytes
		supply <= 1'b1;
		run(3'h0, 32'h4433_2201, 32'h0, 8'h0f, 24'h0, 24'h0,
			32'h0, 1'b1);
		chk(8'(u_flash_memory_model.nbit / 8), 8'h08);
		chk(cb_hi[7:0], 8'h34);
		chk(cb_hi[31:24], 8'h37);
		give_verdict();
	end
endmodule // spi_flash_dma_transfer_engine_test

`default_nettype wire
